// File: design/tx_queue_watermark_monitor.sv
// Contract
// (RQ1) Low watermark byte position is low threshold times 32 times 2048.
// (RQ2) High watermark byte position is high threshold times 32 times 2048.
// (RQ3) The monitored queue carries serial-side data toward Ethernet.
// (RQ4) Bit 3 latches an overflow of the decapsulator-to-memory FIFO.
// (RQ5) Bit 2 latches an overflow of the queue itself.
// (RQ6) Bit 1 latches a crossing of the high watermark.
// (RQ7) Bit 0 latches a crossing of the low watermark.
// (RQ8) Reading the latched register clears it; flags otherwise stay set.
// (RQ9) Enable bits 3..0 gate the flag in the same position, reset zero.
// (RQ10) Interrupt is high while any enabled flag is set.
// (RQ11) A crossing is a change of the fill comparison between clocks.
`timescale 1ns/1ps
module tx_queue_watermark_monitor
(
    input  wire logic                        core_clk_i,
    input  wire logic                        reset_i,
    input  wire logic [8:0]                  reg_addr_i,
    input  wire logic [7:0]                  reg_wdata_i,
    input  wire logic                        reg_wr_i,
    input  wire logic                        reg_rd_i,
    output logic      [7:0]                  reg_rdata_o,
    input  wire logic [wm_pkg::FILL_W-1:0]   queue_fill_i,
    input  wire logic                        queue_overflow_i,
    input  wire logic                        fifo_overflow_i,
    output logic                             irq_o
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0]                low_watermark_value_q;
    logic [7:0]                low_watermark_value_d;
    logic [7:0]                high_watermark_value_q;
    logic [7:0]                high_watermark_value_d;
    logic [7:0]                watermark_irq_enables_q;
    logic [7:0]                watermark_irq_enables_d;
    logic [3:0]                watermark_latched_flags_q;
    logic [3:0]                watermark_latched_flags_d;
    logic [7:0]                rdata_q;
    logic [7:0]                rdata_d;
    logic                      low_cross_state;
    logic                      high_cross_state;
    logic                      low_cross;
    logic                      high_cross;
    logic [3:0]                events;
    logic                      wr_low;
    logic                      wr_high;
    logic                      wr_en;
    logic                      rd_low;
    logic                      rd_high;
    logic                      rd_en;
    logic                      rd_latched;
    logic                      rd_live;
    logic [7:0]                live_state;
    logic                      irq_d;
    logic                      irq_q;

    ////////////////////////////////////////////////////////////////////////
    // RQ3 queue fill compare
    // RQ1 low mark compare
    // RQ11 low crossing edge
    wm_cross_detect u_low
    (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .fill_i     (queue_fill_i),
        .thr_i      (low_watermark_value_q),
        .above_o    (low_cross_state),
        .cross_o    (low_cross)
    );

    // RQ2 high mark compare
    // RQ11 high crossing edge
    wm_cross_detect u_high
    (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .fill_i     (queue_fill_i),
        .thr_i      (high_watermark_value_q),
        .above_o    (high_cross_state),
        .cross_o    (high_cross)
    );

    ////////////////////////////////////////////////////////////////////////
    // Event vector in flag bit order
    always_comb
    begin
        events = '0;
        // RQ7 low crossing event
        events[wm_pkg::LOW_BIT]  = low_cross;
        // RQ6 high crossing event
        events[wm_pkg::HIGH_BIT] = high_cross;
        // RQ5 queue overflow event
        events[wm_pkg::QOVF_BIT] = queue_overflow_i;
        // RQ4 FIFO overflow event
        events[wm_pkg::FOVF_BIT] = fifo_overflow_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // Strobe decode, one select per register
    // Unmapped addresses raise no select, so they are ignored
    always_comb
    begin
        wr_low     = 1'b0;
        wr_high    = 1'b0;
        wr_en      = 1'b0;
        rd_low     = 1'b0;
        rd_high    = 1'b0;
        rd_en      = 1'b0;
        rd_latched = 1'b0;
        rd_live    = 1'b0;
        if (reg_wr_i)
        begin
            wr_low  = (reg_addr_i == wm_pkg::LOW_THR_ADDR);
            wr_high = (reg_addr_i == wm_pkg::HIGH_THR_ADDR);
            wr_en   = (reg_addr_i == wm_pkg::IRQ_EN_ADDR);
        end
        if (reg_rd_i)
        begin
            rd_low     = (reg_addr_i == wm_pkg::LOW_THR_ADDR);
            rd_high    = (reg_addr_i == wm_pkg::HIGH_THR_ADDR);
            rd_en      = (reg_addr_i == wm_pkg::IRQ_EN_ADDR);
            rd_latched = (reg_addr_i == wm_pkg::LATCHED_ADDR);
            rd_live    = (reg_addr_i == wm_pkg::LIVE_STATE_ADDR);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RQ1 low threshold register
    always_comb
    begin
        low_watermark_value_d = low_watermark_value_q;
        if (wr_low)
        begin
            low_watermark_value_d = reg_wdata_i;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            low_watermark_value_q <= wm_pkg::THR_RESET;
        end
        else
        begin
            low_watermark_value_q <= low_watermark_value_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RQ2 high threshold register
    always_comb
    begin
        high_watermark_value_d = high_watermark_value_q;
        if (wr_high)
        begin
            high_watermark_value_d = reg_wdata_i;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            high_watermark_value_q <= wm_pkg::THR_RESET;
        end
        else
        begin
            high_watermark_value_q <= high_watermark_value_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RQ9 enable register, upper bits read zero
    always_comb
    begin
        watermark_irq_enables_d = watermark_irq_enables_q;
        if (wr_en)
        begin
            watermark_irq_enables_d =
                {{(wm_pkg::REG_W - wm_pkg::FLAG_W){1'b0}},
                 reg_wdata_i[wm_pkg::FLAG_W-1:0]};
        end
    end

    // RQ9 enables reset to zero
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            watermark_irq_enables_q <= wm_pkg::EN_RESET;
        end
        else
        begin
            watermark_irq_enables_q <= watermark_irq_enables_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RQ8 clear on read, set wins
    // An event in the reading cycle survives, so no event is lost
    always_comb
    begin
        watermark_latched_flags_d = watermark_latched_flags_q;
        if (rd_latched)
        begin
            watermark_latched_flags_d = wm_pkg::FLAG_RESET;
        end
        watermark_latched_flags_d = watermark_latched_flags_d | events;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            watermark_latched_flags_q <= wm_pkg::FLAG_RESET;
        end
        else
        begin
            watermark_latched_flags_q <= watermark_latched_flags_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Live compare state, read only
    always_comb
    begin
        live_state                   = '0;
        live_state[wm_pkg::LOW_BIT]  = low_cross_state;
        live_state[wm_pkg::HIGH_BIT] = high_cross_state;
    end

    // Read data stand one cycle, zero otherwise
    always_comb
    begin
        rdata_d = '0;
        if (rd_low)
        begin
            rdata_d = low_watermark_value_q;
        end
        else if (rd_high)
        begin
            rdata_d = high_watermark_value_q;
        end
        else if (rd_en)
        begin
            rdata_d = watermark_irq_enables_q;
        end
        else if (rd_latched)
        begin
            rdata_d = {{(wm_pkg::REG_W - wm_pkg::FLAG_W){1'b0}},
                       watermark_latched_flags_q};
        end
        else if (rd_live)
        begin
            rdata_d = live_state;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            rdata_q <= '0;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RQ10 masked interrupt level
    // Built from next values, so it tracks the registers in step
    always_comb
    begin
        irq_d = |(watermark_latched_flags_d
                  & watermark_irq_enables_d[wm_pkg::FLAG_W-1:0]);
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign reg_rdata_o = rdata_q;
    assign irq_o       = irq_q;
endmodule : tx_queue_watermark_monitor

// File: design/wm_pkg.sv
package wm_pkg;
    // Register offsets, plain port addressing
    localparam logic [8:0] LOW_THR_ADDR   = 9'h1_24;
    localparam logic [8:0] HIGH_THR_ADDR  = 9'h1_25;
    localparam logic [8:0] IRQ_EN_ADDR    = 9'h1_26;
    localparam logic [8:0] LATCHED_ADDR   = 9'h1_27;
    localparam logic [8:0] LIVE_STATE_ADDR = 9'h1_28;
    // Field positions of the flag and enable registers
    localparam int LOW_BIT      = 0;
    localparam int HIGH_BIT     = 1;
    localparam int QOVF_BIT     = 2;
    localparam int FOVF_BIT     = 3;
    localparam int FLAG_W       = 4;
    localparam int REG_W        = 8;
    // Threshold scale: 32 packets of 2048 bytes
    localparam int PKTS_PER_STEP  = 32;
    localparam int BYTES_PER_PKT  = 2048;
    localparam int STEP_BYTES     = PKTS_PER_STEP * BYTES_PER_PKT;
    localparam int STEP_SHIFT     = $clog2(STEP_BYTES);
    localparam int FILL_W         = 24;
    localparam logic [7:0] THR_RESET   = 8'h00;
    localparam logic [7:0] EN_RESET    = 8'h00;
    localparam logic [3:0] FLAG_RESET  = 4'h0;
endpackage : wm_pkg

// File: design/wm_cross_detect.sv
`timescale 1ns/1ps
// Flags a change of "fill at or above threshold" between two clocks
module wm_cross_detect
(
    input  wire logic                        core_clk_i,
    input  wire logic                        reset_i,
    input  wire logic [wm_pkg::FILL_W-1:0]   fill_i,
    input  wire logic [7:0]                  thr_i,
    output logic                             above_o,
    output logic                             cross_o
);
    logic [wm_pkg::FILL_W-1:0] mark;
    logic                      above_d;
    logic                      above_q;

    always_comb
    begin
        mark    = wm_pkg::FILL_W'({thr_i, {wm_pkg::STEP_SHIFT{1'b0}}});
        above_d = (fill_i >= mark);
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            above_q <= 1'b0;
        else
            above_q <= above_d;
    end

    assign above_o = above_q;
    assign cross_o = above_d ^ above_q;
endmodule : wm_cross_detect

// File: verif/wm_checker_asserts.sv
`timescale 1ns/1ps
module wm_checker
(
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    input  wire logic [8:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_rdata_o,
    input  wire logic [23:0] queue_fill_i,
    input  wire logic        queue_overflow_i,
    input  wire logic        fifo_overflow_i,
    input  wire logic        irq_o
);
    logic [23:0] fill_q;
    logic        wr_q;
    logic        rst_q;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    always_ff @(posedge core_clk_i)
    begin
        fill_q <= queue_fill_i;
        wr_q   <= reg_wr_i;
        rst_q  <= reset_i;
    end
    // No event and no compare change in this cycle
    wire rd_lat = reg_rd_i && reg_addr_i == wm_pkg::LATCHED_ADDR;
    wire quiet  = !queue_overflow_i && !fifo_overflow_i && !wr_q && !rst_q
                  && queue_fill_i == fill_q;
    sequence ev_s(ev);
        ev ##1 !reg_rd_i ##1 rd_lat;
    endsequence
    sequence wr_rd_s(a);
        reg_wr_i && reg_addr_i == a ##1 !reg_wr_i
            ##1 reg_rd_i && reg_addr_i == a;
    endsequence
    sequence clr_s;
        rd_lat && quiet ##1 !reg_rd_i && quiet ##1 rd_lat && quiet;
    endsequence
    rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data not zero after idle cycle");
    fifo_ovf_a: assert property (
        ev_s(fifo_overflow_i) |=> reg_rdata_o[3])
        else $error("fifo overflow not latched");
    queue_ovf_a: assert property (
        ev_s(queue_overflow_i) |=> reg_rdata_o[2])
        else $error("queue overflow not latched");
    read_clear_a: assert property (
        clr_s |=> reg_rdata_o == 8'h00)
        else $error("flags survive a read");
    irq_clear_a: assert property (rd_lat && quiet |=> !irq_o)
        else $error("interrupt stays after clearing read");
    low_rb_a: assert property (
        wr_rd_s(wm_pkg::LOW_THR_ADDR)
            |=> reg_rdata_o == $past(reg_wdata_i, 3))
        else $error("low threshold readback wrong");
    high_rb_a: assert property (
        wr_rd_s(wm_pkg::HIGH_THR_ADDR)
            |=> reg_rdata_o == $past(reg_wdata_i, 3))
        else $error("high threshold readback wrong");
    en_rb_a: assert property (
        wr_rd_s(wm_pkg::IRQ_EN_ADDR)
            |=> reg_rdata_o == ($past(reg_wdata_i, 3) & 8'h0f))
        else $error("enable readback wrong");
endmodule : wm_checker
bind tx_queue_watermark_monitor wm_checker wm_checker_i
    (.core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
     .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
     .reg_rdata_o(reg_rdata_o), .queue_fill_i(queue_fill_i), .irq_o(irq_o),
     .queue_overflow_i(queue_overflow_i), .fifo_overflow_i(fifo_overflow_i));

// File: verif/tb.sv
`timescale 1ns/1ps
module tb;
    logic        core_clk_i;
    logic        reset_i;
    logic [8:0]  reg_addr_i;
    logic [7:0]  reg_wdata_i;
    logic        reg_wr_i;
    logic        reg_rd_i;
    logic [7:0]  reg_rdata_o;
    logic [23:0] queue_fill_i;
    logic        queue_overflow_i;
    logic        fifo_overflow_i;
    logic        irq_o;
    int          num_errors = 0;
    int          cmp_count = 0;
    logic [23:0] fills [5] = '{24'h01_ffff, 24'h02_0000, 24'h04_ffff,
                               24'h05_0000, 24'h00_0000};
    logic [7:0]  flags [5] = '{8'h00, 8'h01, 8'h00, 8'h02, 8'h03};
    logic [7:0]  lives [5] = '{8'h00, 8'h01, 8'h01, 8'h03, 8'h00};
    tx_queue_watermark_monitor tx_queue_watermark_monitor_i
        (.core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
         .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
         .reg_rdata_o(reg_rdata_o), .queue_fill_i(queue_fill_i), .irq_o(irq_o),
         .queue_overflow_i(queue_overflow_i), .fifo_overflow_i(fifo_overflow_i));
    task automatic chk(input string n, input logic [7:0] e, s);
        cmp_count++;
        if (s !== e)
        begin
            $display("unexpected %s: expected %h, seen %h", n, e, s);
            num_errors++;
        end
    endtask : chk
    task automatic acc(input logic w, input logic [8:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_wr_i <= w;
        reg_rd_i <= !w;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        @(negedge core_clk_i);
    endtask : acc
    task automatic rd(input string n, input logic [8:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk(n, e, reg_rdata_o);
    endtask : rd
    task automatic ev(input logic f, input logic q);
        @(posedge core_clk_i);
        fifo_overflow_i <= f;
        queue_overflow_i <= q;
        @(posedge core_clk_i);
        {fifo_overflow_i, queue_overflow_i} <= 2'b00;
        @(negedge core_clk_i);
    endtask : ev
    task automatic test_done;
        $display("errors %0d, compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done
    initial
    begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    initial
    begin
        {reset_i, reg_wr_i, reg_rd_i} = 3'h4;
        {queue_overflow_i, fifo_overflow_i} = 2'h0;
        {reg_addr_i, reg_wdata_i, queue_fill_i} = '0;
        repeat (10) @(posedge core_clk_i);
        reset_i <= 1'b0;
        for (int i = 0; i < 3; i++)
            rd("reset", wm_pkg::LOW_THR_ADDR + 9'(i), 8'h00);
        rd("latched", wm_pkg::LATCHED_ADDR, 8'h03);
        acc(1'b1, wm_pkg::IRQ_EN_ADDR, 8'hff);
        rd("enables", wm_pkg::IRQ_EN_ADDR, 8'h0f);
        acc(1'b1, 9'h130, 8'h77);
        rd("unmapped", 9'h130, 8'h00);
        acc(1'b1, wm_pkg::LOW_THR_ADDR, 8'h02);
        rd("low", wm_pkg::LOW_THR_ADDR, 8'h02);
        acc(1'b1, wm_pkg::HIGH_THR_ADDR, 8'h05);
        rd("high", wm_pkg::HIGH_THR_ADDR, 8'h05);
        rd("latched", wm_pkg::LATCHED_ADDR, 8'h03);
        for (int i = 0; i < 5; i++)
        begin
            @(posedge core_clk_i);
            queue_fill_i <= fills[i];
            repeat (2) @(negedge core_clk_i);
            chk("irq", {7'h00, flags[i] != 8'h00}, {7'h00, irq_o});
            rd("crossing", wm_pkg::LATCHED_ADDR, flags[i]);
            rd("live", wm_pkg::LIVE_STATE_ADDR, lives[i]);
        end
        acc(1'b1, wm_pkg::IRQ_EN_ADDR, 8'h04);
        ev(1'b1, 1'b0);
        chk("masked irq", 8'h00, {7'h00, irq_o});
        ev(1'b1, 1'b1);
        chk("irq", 8'h01, {7'h00, irq_o});
        rd("overflow", wm_pkg::LATCHED_ADDR, 8'h0c);
        rd("cleared", wm_pkg::LATCHED_ADDR, 8'h00);
        chk("irq after clear", 8'h00, {7'h00, irq_o});
        acc(1'b1, wm_pkg::LOW_THR_ADDR, 8'h10);
        @(posedge core_clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        reset_i <= 1'b0;
        rd("low after reset", wm_pkg::LOW_THR_ADDR, 8'h00);
        rd("en after reset", wm_pkg::IRQ_EN_ADDR, 8'h00);
        rd("latched after reset", wm_pkg::LATCHED_ADDR, 8'h03);
        chk("irq after reset", 8'h00, {7'h00, irq_o});
        test_done();
    end
endmodule : tb
